// File: rtl/decoder_cfg.svh
// Constants for the serial request decoder.
`ifndef DECODER_CFG_SVH
`define DECODER_CFG_SVH
`define FRAME_BITS 17
`define CNT_W 5
`define LEN_BUS_SHORT 5'd7
`define LEN_BUS_LONG 5'd8
`define LEN_READ 5'd9
`define LEN_WRITE 5'd17
`define LEN_ACCEL 5'd6
`define LEN_RESERVED 5'd4
`define SPEED_S100 3'h0
`define SPEED_S200 3'h2
`define SPEED_S400 3'h4
`define EAA_REG 4'h5
`define EAA_BIT 0
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_LAST_WRITE 8'h08
`define CONTROL_RESET 32'h0000_0001
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`endif

// File: rtl/request_pkg.sv
// Types shared by the serial request decoder.
package request_pkg;
  typedef enum logic [2:0] {
    REQ_IMMEDIATE = 3'h0,
    REQ_ISOCHRONOUS = 3'h1,
    REQ_PRIORITY = 3'h2,
    REQ_FAIR = 3'h3,
    REQ_READ = 3'h4,
    REQ_WRITE = 3'h5,
    REQ_ACCEL = 3'h6,
    REQ_RESERVED = 3'h7
  } req_type_e;
  typedef enum logic [1:0] {
    CTL_IDLE = 2'h0,
    CTL_STATUS = 2'h1,
    CTL_RECEIVE = 2'h2,
    CTL_GRANT = 2'h3
  } ctl_code_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } parse_state_e;
  typedef struct packed {
    logic valid;
    req_type_e kind;
    logic [2:0] speed;
    logic bad_speed;
  } bus_req_s;
  typedef struct packed {
    logic pending;
    logic [3:0] addr;
    logic [7:0] data;
  } read_req_s;
endpackage

// File: rtl/link_request_serial_decoder.sv
// Serial request decoder with its small register file and bus slave.
`include "decoder_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// RQ1 - Bus request: start, type, speed, optional stop.
// RQ2 - Speed codes 000, 010, 100 valid only.
// RQ3 - Invalid speed arbitrates, then sends null packet.
// RQ4 - Read request: nine bits, four-bit address.
// RQ5 - Write request: seventeen bits, address, data byte.
// RQ6 - Accel request: six bits, one control bit.
// RQ7 - Link waits one clock after idle.
// RQ8 - Receive code clears pending fair/priority.
// RQ9 - Fair/priority in flight during receive dropped.
// RQ10 - Link sequences cycle start and isochronous.
// RQ11 - Isochronous request held until bus won.
// RQ12 - Link sends immediate request during reception.
// RQ13 - Immediate request granted when reception ends.
// RQ14 - Link abandons grant on bad header.
// RQ15 - Link keeps one bus request outstanding.
// RQ16 - New bus request ignored; bus reset clears.
// RQ17 - Write stores byte when frame completes.
// RQ18 - Read held until status transfer succeeds.
// RQ19 - Register requests anytime; one read outstanding.
// RQ20 - Acceleration active only with enable bit.
// RQ21 - Accel request immediate; reset, iso re-enable.
// RQ22 - Link toggles acceleration around cycle start.
// RQ23 - Type field encodes seven request kinds.
// RQ24 - Line rests low, MSB first, start one.
// RQ25 - Everything sampled on rising clock edge.
// RQ26 - Control codes idle, status, receive, grant.
// RQ27 - Seven-bit bus request ends after last speed.
module link_request_serial_decoder #(
  parameter int NUM_PHY_REGS = 16
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link side.
  input wire logic link_request_line,
  input wire request_pkg::ctl_code_e interface_control_bus,
  // Arbitration and status events.
  input wire logic bus_won,
  input wire logic bus_reset,
  input wire logic read_delivered,
  // Decoded results.
  output request_pkg::bus_req_s bus_request,
  output request_pkg::read_req_s read_request,
  output logic immediate_grant,
  output logic transmit_null,
  output logic arbitration_accel_enable,
  output logic accel_active
);
  import request_pkg::*;

  if (NUM_PHY_REGS != 16) begin : g_check
    $error("The four-bit address needs exactly 16 registers.");
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] frame_len(input logic [2:0] kind,
                                           input logic last_speed);
    case (kind)
      REQ_IMMEDIATE, REQ_ISOCHRONOUS, REQ_PRIORITY, REQ_FAIR: begin
        frame_len = last_speed ? `LEN_BUS_LONG : `LEN_BUS_SHORT; // [RQ1]
      end
      REQ_READ: frame_len = `LEN_READ; // [RQ4]
      REQ_WRITE: frame_len = `LEN_WRITE; // [RQ5]
      REQ_ACCEL: frame_len = `LEN_ACCEL; // [RQ6]
      default: frame_len = `LEN_RESERVED;
    endcase
  endfunction

  function automatic logic speed_bad(input logic [2:0] spd);
    speed_bad = !(spd == `SPEED_S100 || spd == `SPEED_S200 ||
                  spd == `SPEED_S400); // [RQ2]
  endfunction

  ////////////////////////////////////////////////////////////////////////
  parse_state_e state, next_state;
  logic [`FRAME_BITS-1:0] frm, next_frm;
  logic [`CNT_W-1:0] cnt, next_cnt;
  logic rx_seen, next_rx_seen;
  logic done;
  logic [2:0] f_type, f_speed;
  logic [3:0] f_addr;
  logic [7:0] f_data;
  logic enable;
  logic in_receive;

  assign in_receive = interface_control_bus == CTL_RECEIVE;

  // Bit 0 arrives first and lands in frm[0].
  always_comb begin
    next_state = state;
    next_frm = frm;
    next_cnt = cnt;
    next_rx_seen = rx_seen;
    done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (enable && link_request_line) begin // [RQ24] [RQ25]
          next_state = ST_SHIFT;
          next_frm = '0;
          next_frm[0] = 1'b1;
          next_cnt = 5'd1;
          next_rx_seen = in_receive;
        end
      end
      ST_SHIFT: begin
        next_frm[cnt] = link_request_line;
        next_cnt = cnt + 5'd1;
        next_rx_seen = rx_seen | in_receive; // [RQ9]
        if (next_cnt >= 5'd4 && next_cnt ==
            frame_len({next_frm[1], next_frm[2], next_frm[3]},
                      next_frm[6])) begin // [RQ27]
          done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      frm <= '0;
      cnt <= '0;
      rx_seen <= 1'b0;
    end else begin
      state <= next_state;
      frm <= next_frm;
      cnt <= next_cnt;
      rx_seen <= next_rx_seen;
    end
  end

  assign f_type = {next_frm[1], next_frm[2], next_frm[3]}; // [RQ23]
  assign f_speed = {next_frm[4], next_frm[5], next_frm[6]};
  assign f_addr = {next_frm[4], next_frm[5], next_frm[6], next_frm[7]};
  assign f_data = {next_frm[8], next_frm[9], next_frm[10],
                   next_frm[11], next_frm[12], next_frm[13],
                   next_frm[14], next_frm[15]};

  ////////////////////////////////////////////////////////////////////////
  // A stop bit of one marks a broken frame, so it is dropped whole.
  logic stop_ok;
  logic is_bus, is_fp;
  logic [7:0] phy_reg [NUM_PHY_REGS];
  logic [7:0] next_phy_reg [NUM_PHY_REGS];
  bus_req_s next_bus;
  read_req_s next_read;
  logic accel_on, next_accel_on;
  logic next_null;
  ctl_code_e ctl_prev;
  logic rx_end;

  assign is_bus = f_type[2] == 1'b0;
  assign is_fp = f_type == REQ_PRIORITY || f_type == REQ_FAIR;
  assign stop_ok = !next_frm[next_cnt - 5'd1];
  assign rx_end = ctl_prev == CTL_RECEIVE && !in_receive;

  always_comb begin
    next_bus = bus_request;
    next_read = read_request;
    next_accel_on = accel_on;
    next_null = transmit_null;
    for (int i = 0; i < NUM_PHY_REGS; i++) begin
      next_phy_reg[i] = phy_reg[i];
    end
    if (bus_won) begin
      next_null = bus_request.valid && bus_request.bad_speed; // [RQ3]
      next_bus.valid = 1'b0; // [RQ11]
    end
    if (in_receive && (bus_request.kind == REQ_PRIORITY ||
                       bus_request.kind == REQ_FAIR)) begin
      next_bus.valid = 1'b0; // [RQ8]
    end
    if (bus_reset) begin
      next_bus.valid = 1'b0; // [RQ16]
      next_accel_on = 1'b1; // [RQ21]
      next_null = 1'b0;
    end
    if (read_delivered) begin
      next_read.pending = 1'b0; // [RQ18]
    end
    if (done && stop_ok) begin
      if (is_bus && !bus_request.valid &&
          !(is_fp && (rx_seen || in_receive))) begin // [RQ9] [RQ16]
        next_bus.valid = 1'b1;
        next_bus.kind = req_type_e'(f_type);
        next_bus.speed = f_speed;
        next_bus.bad_speed = speed_bad(f_speed); // [RQ3]
        if (f_type == REQ_ISOCHRONOUS) begin
          next_accel_on = 1'b1; // [RQ21]
        end
      end
      if (f_type == REQ_READ &&
          (!read_request.pending || read_delivered)) begin // [RQ19]
        next_read.pending = 1'b1;
        next_read.addr = f_addr;
      end
      if (f_type == REQ_WRITE) begin
        next_phy_reg[f_addr] = f_data; // [RQ17]
      end
      if (f_type == REQ_ACCEL) begin
        next_accel_on = next_frm[4]; // [RQ21]
      end
    end
    next_read.data = next_phy_reg[next_read.addr]; // [RQ18]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_request <= '0;
      read_request <= '0;
      accel_on <= 1'b1;
      transmit_null <= 1'b0;
      ctl_prev <= CTL_IDLE;
      for (int i = 0; i < NUM_PHY_REGS; i++) begin
        phy_reg[i] <= 8'h00;
      end
    end else begin
      bus_request <= next_bus;
      read_request <= next_read;
      accel_on <= next_accel_on;
      transmit_null <= next_null;
      ctl_prev <= interface_control_bus; // [RQ26]
      for (int i = 0; i < NUM_PHY_REGS; i++) begin
        phy_reg[i] <= next_phy_reg[i];
      end
    end
  end

  assign arbitration_accel_enable = phy_reg[`EAA_REG][`EAA_BIT];
  assign accel_active = accel_on && arbitration_accel_enable; // [RQ20]
  // No arbitration wait: the grant follows the last receive cycle.
  assign immediate_grant = bus_request.valid &&
                           bus_request.kind == REQ_IMMEDIATE &&
                           rx_end; // [RQ13]

  ////////////////////////////////////////////////////////////////////////
  // Zero wait states; a write address phase is caught and decoded next; a read is decoded in its own address phase.
  logic [31:0] control, next_control;
  logic [31:0] next_hrdata;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_ofs, next_wr_ofs;
  logic [11:0] last_write, next_last_write;
  logic take;

  assign take = hsel && hready && htrans == `HTRANS_NONSEQ;
  assign enable = control[0];

  always_comb begin
    next_control = control;
    next_wr_pend = take && hwrite;
    next_wr_ofs = haddr[7:0];
    next_hrdata = hrdata;
    next_last_write = last_write;
    if (done && stop_ok && f_type == REQ_WRITE) begin
      next_last_write = {f_addr, f_data};
    end
    if (wr_pend && wr_ofs == `OFS_CONTROL) begin
      next_control = {31'h0000_0000, hwdata[0]};
    end
    if (take && !hwrite) begin
      case (haddr[7:0])
        `OFS_CONTROL: next_hrdata = control;
        `OFS_STATUS: next_hrdata = {18'h0_0000, accel_active,
                                    read_request.addr,
                                    read_request.pending,
                                    bus_request.bad_speed,
                                    bus_request.speed,
                                    bus_request.kind,
                                    bus_request.valid};
        `OFS_LAST_WRITE: next_hrdata = {20'h0_0000, last_write};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control <= `CONTROL_RESET;
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      hrdata <= 32'h0000_0000;
      last_write <= 12'h000;
    end else begin
      control <= next_control;
      wr_pend <= next_wr_pend;
      wr_ofs <= next_wr_ofs;
      hrdata <= next_hrdata;
      last_write <= next_last_write;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule
`default_nettype wire

// File: sim/link_model.sv
// Behavioural link controller that drives the serial request line.
`timescale 1ns/1ps
`default_nettype none
module link_model (
  // Clock and control bus.
  input wire logic hclk,
  input wire request_pkg::ctl_code_e ctl,
  // Serial request line.
  output logic line
);
  import request_pkg::*;
  initial line = 1'b0;
  // The frame is held left aligned so bit zero always sits at the top.
  task automatic send(logic [16:0] f, int n, logic wait_idle);
    if (wait_idle) begin
      @(posedge hclk);
      while (ctl != CTL_IDLE) @(posedge hclk);
    end
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      line <= f[16 - i];
    end
    @(posedge hclk);
    line <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/decoder_checker.sv
// Concurrent checks on the decoder outputs.
`timescale 1ns/1ps
`default_nettype none
module decoder_checker (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Events.
  input wire request_pkg::ctl_code_e interface_control_bus,
  input wire logic bus_won,
  input wire logic bus_reset,
  input wire logic read_delivered,
  // Results.
  input wire request_pkg::bus_req_s bus_request,
  input wire request_pkg::read_req_s read_request,
  input wire logic immediate_grant,
  input wire logic transmit_null,
  input wire logic arbitration_accel_enable,
  input wire logic accel_active
);
  import request_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rx_end;
    interface_control_bus == CTL_RECEIVE ##1
    interface_control_bus != CTL_RECEIVE;
  endsequence
  property p_grant;
    s_rx_end ##0 bus_request.valid && bus_request.kind == REQ_IMMEDIATE
    |-> immediate_grant;
  endproperty
  a_grant: assert property (p_grant) else $error("grant missing");
  property p_rx_clear;
    interface_control_bus == CTL_RECEIVE && bus_request.valid &&
    bus_request.kind inside {REQ_PRIORITY, REQ_FAIR} |=> !bus_request.valid;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("not cleared");
  property p_iso_hold;
    bus_request.valid && bus_request.kind == REQ_ISOCHRONOUS && !bus_won &&
    !bus_reset |=> bus_request.valid && bus_request.kind == REQ_ISOCHRONOUS;
  endproperty
  a_iso_hold: assert property (p_iso_hold) else $error("iso lost");
  property p_ignore;
    bus_request.valid && !bus_won && !bus_reset &&
    interface_control_bus != CTL_RECEIVE |=> $stable(bus_request);
  endproperty
  a_ignore: assert property (p_ignore) else $error("request moved");
  property p_read_hold;
    read_request.pending && !read_delivered
    |=> read_request.pending && $stable(read_request.addr);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read lost");
  property p_null;
    bus_won && bus_request.valid && !bus_reset
    |=> transmit_null == $past(bus_request.bad_speed);
  endproperty
  a_null: assert property (p_null) else $error("null flag wrong");
  property p_speed;
    bus_request.valid |-> bus_request.bad_speed ==
    !(bus_request.speed inside {3'h0, 3'h2, 3'h4});
  endproperty
  a_speed: assert property (p_speed) else $error("speed flag wrong");
  property p_accel;
    accel_active |-> arbitration_accel_enable;
  endproperty
  a_accel: assert property (p_accel) else $error("accel ungated");
  // The gate alone holds by construction; a bus reset must also re-arm it.
  property p_reset_accel;
    bus_reset |=> accel_active == arbitration_accel_enable;
  endproperty
  a_reset_accel: assert property (p_reset_accel)
    else $error("accel not re-armed");
endmodule
bind link_request_serial_decoder decoder_checker chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .interface_control_bus(interface_control_bus),
  .bus_won(bus_won),
  .bus_reset(bus_reset),
  .read_delivered(read_delivered),
  .bus_request(bus_request),
  .read_request(read_request),
  .immediate_grant(immediate_grant),
  .transmit_null(transmit_null),
  .arbitration_accel_enable(arbitration_accel_enable),
  .accel_active(accel_active)
);
`default_nettype wire

// File: sim/test_link_request_serial_decoder.sv
// Self-checking bench for the serial request decoder.
`include "decoder_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_link_request_serial_decoder;
  import request_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic bus_won = 1'b0;
  logic bus_reset = 1'b0;
  logic read_delivered = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = `HSIZE_WORD;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, line, igrant, tnull, aen, aact;
  ctl_code_e ctl = CTL_IDLE;
  bus_req_s br;
  read_req_s rr;
  logic [7:0] regs [16] = '{default: 8'h00};
  logic [7:0] d;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int ev = 0, ek = 0, es = 0, ep = 0, ea = 0, aon = 1, enull = 0;
  always #4 hclk = ~hclk;
  link_model link (.hclk(hclk), .ctl(ctl), .line(line));
  link_request_serial_decoder uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .link_request_line(line),
    .interface_control_bus(ctl), .bus_won(bus_won), .bus_reset(bus_reset),
    .read_delivered(read_delivered), .bus_request(br), .read_request(rr),
    .immediate_grant(igrant), .transmit_null(tnull),
    .arbitration_accel_enable(aen), .accel_active(aact));
  task automatic give_verdict;
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic cmp_val(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (exp !== got) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic int bad(int s);
    return !(s inside {0, 2, 4});
  endfunction
  task automatic cmp;
    #1;
    if (ev) cmp_val("bus_request", {1'b1, ek[2:0], es[2:0], 1'(bad(es))}, br);
    else cmp_val("bus_valid", 0, br.valid);
    cmp_val("read_pending", ep, rr.pending);
    if (ep) cmp_val("read_request", {ea[3:0], regs[ea]}, rr[11:0]);
    cmp_val("transmit_null", enull, tnull);
    cmp_val("accel_active", aon & regs[5][0], aact);
    cmp_val("accel_enable", regs[5][0], aen);
  endtask
  task automatic ahb(logic wr, logic [31:0] a, logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    cmp_val("hresp", 0, hresp);
    hsel <= 1'b0;
  endtask
  task automatic bus(int t, int s);
    link.send({1'b1, t[2:0], s[2:0], 10'h0}, s[0] ? 8 : 7, t inside {2, 3});
    if (!ev) begin
      ev = 1;
      ek = t;
      es = s;
      if (t == 1) aon = 1;
    end
    cmp();
  endtask
  task automatic reg_wr(int a, logic [7:0] v);
    link.send({1'b1, 3'b101, a[3:0], v, 1'b0}, 17, 1'b0);
    regs[a] = v;
    cmp();
  endtask
  task automatic rd_req(int a);
    link.send({1'b1, 3'b100, a[3:0], 1'b0, 8'h0}, 9, 1'b0);
    if (!ep) begin
      ep = 1;
      ea = a;
    end
    cmp();
  endtask
  task automatic accel(int c);
    link.send({1'b1, 3'b110, c[0], 1'b0, 11'h0}, 6, 1'b0);
    aon = c;
    cmp();
  endtask
  // Selector 0 wins the bus, 1 resets it, 2 completes a register status.
  task automatic pulse(int which);
    @(posedge hclk);
    if (which == 0) bus_won <= 1'b1;
    else if (which == 1) bus_reset <= 1'b1;
    else read_delivered <= 1'b1;
    @(posedge hclk);
    bus_won <= 1'b0;
    bus_reset <= 1'b0;
    read_delivered <= 1'b0;
    if (which == 0) enull = ev && bad(es);
    if (which == 1) enull = 0;
    if (which == 1) aon = 1;
    if (which < 2) ev = 0;
    if (which == 2) ep = 0;
    cmp();
  endtask
  initial begin
    void'($urandom(32'h9BF9C4E0));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    cmp();
    ahb(1'b0, `OFS_CONTROL, 0);
    cmp_val("control", `CONTROL_RESET, rd);
    ahb(1'b0, 32'h0000_0040, 0);
    cmp_val("unmapped", 0, rd);
    ahb(1'b1, `OFS_CONTROL, 0);
    link.send({1'b1, 3'b001, 3'h0, 10'h0}, 7, 1'b0);
    cmp();
    ahb(1'b1, `OFS_CONTROL, 1);
    reg_wr(5, 8'h01);
    d = 8'($urandom);
    reg_wr(3, d);
    // A write whose stop bit is one must leave the register untouched.
    link.send({1'b1, 3'b101, 4'h3, ~d, 1'b1}, 17, 1'b0);
    cmp();
    link.send({1'b1, 3'b111, 13'h0000}, 4, 1'b0);
    cmp();
    ahb(1'b0, `OFS_LAST_WRITE, 0);
    cmp_val("last_write", {4'h3, d}, rd[11:0]);
    accel(0);
    for (int t = 0; t < 4; t++) begin
      bus(t, t == 3 ? $urandom_range(7, 5) : 2 * t);
      bus(3 - t, 0);
      pulse(0);
    end
    accel(0);
    bus(3, 2);
    ahb(1'b0, `OFS_STATUS, 0);
    cmp_val("status", {1'b0, 3'h2, 3'h3, 1'b1}, rd[7:0]);
    rd_req(3);
    rd_req(5);
    pulse(1);
    pulse(2);
    rd_req(5);
    pulse(2);
    for (int t = 2; t > 0; t--) begin
      bus(t, 4);
      @(posedge hclk);
      ctl <= CTL_RECEIVE;
      @(posedge hclk);
      ctl <= CTL_IDLE;
      if (t == 2) ev = 0;
      cmp();
    end
    pulse(0);
    fork
      link.send({1'b1, 3'b011, 3'h0, 10'h0}, 7, 1'b1);
      begin
        repeat (4) @(posedge hclk);
        ctl <= CTL_RECEIVE;
        @(posedge hclk);
        ctl <= CTL_IDLE;
      end
    join
    cmp();
    @(posedge hclk);
    ctl <= CTL_RECEIVE;
    bus(0, 0);
    @(posedge hclk);
    ctl <= CTL_IDLE;
    #1;
    cmp_val("immediate_grant", 1, igrant);
    pulse(0);
    cmp_val("immediate_grant", 0, igrant);
    give_verdict();
  end
endmodule
`default_nettype wire
